// file: flash_bus_sva.sv
// Purpose: Flash pin timing checks for the NOR flash host.
// Assumes: One clock; synchronous active-low reset.
// Notes: Cycle figures follow the host's setup, pulse and recovery counts.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_sva #(parameter ADDR_W = 22, parameter DATA_W = 16) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [DATA_W-1:0] flash_dq_out,
   input wire logic flash_dq_oe,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic output_drive_n,
   input wire logic flash_reset_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_setup;
      (write_strobe_n && output_drive_n)[*3] ##1 !(write_strobe_n && output_drive_n);
   endsequence
   sequence s_wpulse;
      ##1 (!write_strobe_n)[*8] ##1 write_strobe_n;
   endsequence
   sequence s_rpulse;
      ##22 !output_drive_n ##1 output_drive_n;
   endsequence
   AST_SETUP: assert property ($fell(chip_select_n) |-> s_setup)
      else $error("strobe not 3 cycles after select");
   AST_WPULSE: assert property ($fell(write_strobe_n) |-> s_wpulse)
      else $error("write pulse not 9 cycles");
   AST_RPULSE: assert property ($fell(output_drive_n) |-> s_rpulse)
      else $error("read pulse not 23 cycles");
   AST_RECOVER: assert property ($rose(chip_select_n) |-> chip_select_n[*4])
      else $error("select released under 4 cycles");
   AST_STROBE_IN_CS: assert property (!write_strobe_n || !output_drive_n |-> !chip_select_n)
      else $error("strobe outside select");
   AST_WRITE_DRIVES: assert property (!write_strobe_n |-> flash_dq_oe && output_drive_n)
      else $error("write without bus drive");
   AST_READ_FLOATS: assert property (!output_drive_n |-> !flash_dq_oe)
      else $error("host drives bus in read");
   AST_ADDR_STABLE: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(flash_addr))
      else $error("address moved in cycle");
   AST_DATA_STABLE: assert property (!write_strobe_n && !$past(write_strobe_n) |-> $stable(flash_dq_out))
      else $error("data moved in write pulse");
   AST_RESET_PIN: assert property (disable iff (1'b0) !aresetn |=> !flash_reset_n && chip_select_n)
      else $error("flash not held in reset");
endmodule
`default_nettype wire

// file: flash_model.sv
// Purpose: Behavioural NOR flash: 16 words, armed two-cycle program, suspend, status bits, reset.
// Assumes: Sampled on the host clock; only the low four address bits select a word.
// Notes: A released bus shows the inverse of the last driven value.
`timescale 1ns/1ps
`default_nettype none
module flash_model #(parameter int BUSY = 40) (
   input wire logic clk,
   input wire logic [21:0] addr,
   input wire logic lsb,
   input wire logic [15:0] dq_wr,
   input wire logic cs_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic rst_n,
   input wire logic guard_n,
   output logic [15:0] dq_rd,
   output logic rdy,
   output logic [22:0] last_wr
);
   logic [15:0] mem [0:15];
   logic [15:0] pdat, last;
   logic [3:0] pidx;
   logic armed, tog, susp, we_q, oe_q;
   int cnt;
   initial
   begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      {armed, tog, susp, cnt, last} = '0;
      {we_q, oe_q} = 2'h3;
   end
   assign rdy = (cnt == 0) || susp;
   always_comb
      if (cs_n || oe_n) dq_rd = ~last;
      else if (cnt != 0 && !susp) dq_rd = {pdat[15:8], ~pdat[7], tog, pdat[5:0]};
      else dq_rd = mem[addr[3:0]];
   always @(posedge clk)
   begin
      we_q <= we_n;
      oe_q <= oe_n;
      if (!cs_n && !oe_n) last <= dq_rd;
      if (!rst_n)
      begin
         armed <= 0;
         cnt <= 0;
         susp <= 0;
      end
      // A write while busy only suspends or resumes; the paused count keeps the work pending.
      else if (cnt != 0 && !we_q && we_n && !cs_n)
         susp <= (dq_wr[7:0] == 8'hB0) || (susp && dq_wr[7:0] != 8'h30);
      else if (cnt != 0 && !susp)
      begin
         if (oe_n && !oe_q) tog <= ~tog;
         if (cnt == 1) mem[pidx] <= mem[pidx] & pdat;
         cnt <= cnt - 1;
      end
      else if (!we_q && we_n && !cs_n)
      begin
         last_wr <= {addr, lsb};
         armed <= !armed && dq_wr[7:0] == 8'hA0;
         pidx <= addr[3:0];
         pdat <= dq_wr;
         if (armed && (guard_n || addr[3:0] != 4'h0)) cnt <= BUSY;
      end
   end
endmodule
`default_nettype wire

// file: nor_flash_host.v
// Purpose: Host controller that drives an asynchronous parallel NOR flash from AXI4-Lite registers.
// Assumes: Flash pins are sampled synchronously to aclk; the two-way data bus is resolved outside.
// Notes:   Software composes command sequences from single bus cycles and status waits.
//
// How it works
// - Chip select, write strobe and output drive are driven separately, all active low.
// - Each OP_WRITE order written to the control register in ST_IDLE becomes one flash write cycle with address and data.
// - Completion found by complement bit, toggle bit or ready/busy input polling.
// - Bypass programming is two write cycles, issued by software as two orders.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "nor_flash_host_map.vh"

module nor_flash_host #(
   parameter ADDR_W = 22,
   parameter DATA_W = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] awaddr,
   input wire awvalid,
   output reg awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output reg wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [7:0] araddr,
   input wire arvalid,
   output reg arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   output reg irq,
   output reg [ADDR_W-1:0] flash_addr,
   output reg byte_addr_lsb,
   output reg [DATA_W-1:0] flash_dq_out,
   output reg flash_dq_oe,
   input wire [DATA_W-1:0] flash_dq_in,
   output reg chip_select_n,
   output reg write_strobe_n,
   output reg output_drive_n,
   output reg width_select_n,
   output reg flash_reset_n,
   output reg edge_sector_guard_boost,
   input wire ready_busy_out
);

   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_SETUP = 6'h02;
   localparam [5:0] ST_STROBE = 6'h04;
   localparam [5:0] ST_RECOVER = 6'h08;
   localparam [5:0] ST_WAIT_RB = 6'h10;
   localparam [5:0] ST_SPARE = 6'h20;
   localparam integer SETUP_LEN = `SETUP_CYC;
   localparam integer READ_LEN = `READ_CYC;
   localparam integer WRITE_LEN = `WRITE_CYC;
   localparam integer RECOVER_LEN = `RECOVER_CYC;
   // The counts are cut to the 8-bit counter on purpose; every one of them stays far below 256.
   localparam [7:0] SETUP_CYC = SETUP_LEN[7:0];
   localparam [7:0] READ_CYC = READ_LEN[7:0];
   localparam [7:0] WRITE_CYC = WRITE_LEN[7:0];
   localparam [7:0] RECOVER_CYC = RECOVER_LEN[7:0];

   reg aw_got;
   reg w_got;
   reg [7:0] wr_addr;
   reg [31:0] wr_data;
   reg [3:0] wr_strb;
   reg [31:0] addr_reg;
   reg [31:0] wdata_reg;
   reg [DATA_W-1:0] rdata_reg;
   reg [2:0] config_reg;
   reg [1:0] int_stat;
   reg [1:0] int_mask;
   reg [2:0] op;
   reg [5:0] state;
   reg [7:0] cnt;
   reg prev_toggle;
   reg sample_prev6;
   reg [1:0] reads_seen;
   reg [1:0] int_set;
   reg [1:0] int_clr;
   reg [31:0] rd_mux;
   reg rd_ok;
   wire wr_fire;
   wire [31:0] wmask;
   wire go;
   wire [DATA_W-1:0] sample;

   assign wr_fire = aw_got & w_got & ~bvalid;
   assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   // Orders written while a cycle is running are dropped, never queued.
   assign go = wr_fire & (wr_addr == `REG_CTRL) & (state == ST_IDLE) & wr_strb[0];
   assign sample = flash_dq_in;

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
      end
      else
      begin
         awready <= awvalid & ~awready & ~aw_got & ~bvalid;
         wready <= wvalid & ~wready & ~w_got & ~bvalid;
         if (awvalid & awready)
         begin
            aw_got <= 1'b1;
            wr_addr <= {awaddr[7:2], 2'b00};
         end
         if (wvalid & wready)
         begin
            w_got <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_fire)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (wr_addr > `REG_INT_MASK || wr_addr == `REG_RDATA || wr_addr == `REG_STATUS)
                     ? `RESP_SLVERR : `RESP_OKAY;
         end
         else if (bvalid & bready)
            bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   always @*
   begin
      rd_ok = 1'b1;
      case ({araddr[7:2], 2'b00})
         `REG_ADDR: rd_mux = addr_reg;
         `REG_WDATA: rd_mux = wdata_reg;
         `REG_RDATA: rd_mux = {{(32-DATA_W){1'b0}}, rdata_reg};
         `REG_STATUS: rd_mux = {28'h0000000, prev_toggle, ready_busy_out, 1'b0, state != ST_IDLE};
         `REG_CONFIG: rd_mux = {29'h00000000, config_reg};
         `REG_INT_STAT: rd_mux = {30'h00000000, int_stat};
         `REG_INT_MASK: rd_mux = {30'h00000000, int_mask};
         `REG_CTRL: rd_mux = {29'h00000000, op};
         default:
         begin
            rd_mux = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `RESP_OKAY;
      end
      else
      begin
         arready <= arvalid & ~arready & ~rvalid;
         if (arvalid & arready)
         begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (rvalid & rready)
            rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Software registers and interrupt
   // ----------------------------------------
   always @*
   begin
      int_clr = 2'b00;
      if (arvalid & arready & ({araddr[7:2], 2'b00} == `REG_INT_STAT))
         int_clr = 2'b11;
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         addr_reg <= 32'h00000000;
         wdata_reg <= 32'h00000000;
         config_reg <= `CFG_RESET;
         int_mask <= 2'b00;
         int_stat <= 2'b00;
         irq <= 1'b0;
      end
      else
      begin
         if (wr_fire & (wr_addr == `REG_ADDR))
            addr_reg <= (addr_reg & ~wmask) | (wr_data & wmask);
         if (wr_fire & (wr_addr == `REG_WDATA))
            wdata_reg <= (wdata_reg & ~wmask) | (wr_data & wmask);
         if (wr_fire & (wr_addr == `REG_CONFIG) & wr_strb[0])
            config_reg <= wr_data[2:0];
         if (wr_fire & (wr_addr == `REG_INT_MASK) & wr_strb[0])
            int_mask <= wr_data[1:0];
         // A completion in the same cycle as the clearing read stays pending.
         int_stat <= (int_stat & ~int_clr) | int_set;
         irq <= |(((int_stat & ~int_clr) | int_set) & int_mask);
      end
   end

   // ----------------------------------------
   // Flash bus cycle engine
   // ----------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ST_IDLE;
         op <= `OP_READ;
         cnt <= 8'h00;
         prev_toggle <= 1'b0;
         rdata_reg <= {DATA_W{1'b0}};
         int_set <= 2'b00;
         flash_addr <= {ADDR_W{1'b0}};
         byte_addr_lsb <= 1'b0;
         flash_dq_out <= {DATA_W{1'b0}};
         flash_dq_oe <= 1'b0;
         chip_select_n <= 1'b1;
         write_strobe_n <= 1'b1;
         output_drive_n <= 1'b1;
         width_select_n <= 1'b1;
         flash_reset_n <= 1'b0;
         edge_sector_guard_boost <= 1'b1;
      end
      else
      begin
         int_set <= 2'b00;
         width_select_n <= ~config_reg[`CFG_BYTE_MODE];
         flash_reset_n <= ~config_reg[`CFG_RESET_ASSERT];
         edge_sector_guard_boost <= ~config_reg[`CFG_GUARD_LOW];
         case (state)
            ST_IDLE:
            begin
               // Chip select idles high so the part can drop to standby.
               chip_select_n <= 1'b1;
               flash_dq_oe <= 1'b0;
               if (go)
               begin
                  op <= wr_data[2:0];
                  // In byte mode ADDR bit 0 is the byte select; the rest is the word address.
                  if (config_reg[`CFG_BYTE_MODE])
                  begin
                     flash_addr <= addr_reg[ADDR_W:1];
                     byte_addr_lsb <= addr_reg[0];
                  end
                  else
                  begin
                     flash_addr <= addr_reg[ADDR_W-1:0];
                     byte_addr_lsb <= 1'b0;
                  end
                  flash_dq_out <= wdata_reg[DATA_W-1:0];
                  if (wr_data[2:0] == `OP_WAIT_READY)
                     state <= ST_WAIT_RB;
                  else
                  begin
                     chip_select_n <= 1'b0;
                     flash_dq_oe <= (wr_data[2:0] == `OP_WRITE);
                     cnt <= SETUP_CYC;
                     state <= ST_SETUP;
                  end
               end
            end
            ST_SETUP:
            begin
               if (cnt > 8'h01)
                  cnt <= cnt - 8'h01;
               else if (op == `OP_WRITE)
               begin
                  write_strobe_n <= 1'b0;
                  cnt <= WRITE_CYC;
                  state <= ST_STROBE;
               end
               else
               begin
                  output_drive_n <= 1'b0;
                  cnt <= READ_CYC;
                  state <= ST_STROBE;
               end
            end
            ST_STROBE:
            begin
               if (cnt > 8'h01)
                  cnt <= cnt - 8'h01;
               else
               begin
                  write_strobe_n <= 1'b1;
                  output_drive_n <= 1'b1;
                  if (op != `OP_WRITE)
                  begin
                     rdata_reg <= sample;
                     prev_toggle <= sample[6];
                  end
                  cnt <= RECOVER_CYC;
                  state <= ST_RECOVER;
               end
            end
            ST_RECOVER:
            begin
               chip_select_n <= 1'b1;
               flash_dq_oe <= 1'b0;
               if (cnt > 8'h01)
                  cnt <= cnt - 8'h01;
               // Complement polling ends when bit 7 equals the data that was programmed.
               else if (op == `OP_POLL_COMPLEMENT && rdata_reg[7] != wdata_reg[7])
               begin
                  chip_select_n <= 1'b0;
                  cnt <= SETUP_CYC;
                  state <= ST_SETUP;
               end
               // Toggle polling needs two reads; it ends once bit 6 stops changing.
               else if (op == `OP_POLL_TOGGLE && (reads_seen != 2'b10 || prev_toggle != sample_prev6))
               begin
                  chip_select_n <= 1'b0;
                  cnt <= SETUP_CYC;
                  state <= ST_SETUP;
               end
               else
               begin
                  int_set[`INT_OP_DONE] <= (op == `OP_READ || op == `OP_WRITE);
                  int_set[`INT_WAIT_DONE] <= (op != `OP_READ && op != `OP_WRITE);
                  state <= ST_IDLE;
               end
            end
            ST_WAIT_RB:
            begin
               if (ready_busy_out)
               begin
                  int_set[`INT_WAIT_DONE] <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Previous toggle sample for the bit 6 comparison
   // ----------------------------------------

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sample_prev6 <= 1'b0;
         reads_seen <= 2'b00;
      end
      else if (state == ST_IDLE)
         reads_seen <= 2'b00;
      else if (state == ST_STROBE && cnt <= 8'h01 && op == `OP_POLL_TOGGLE)
      begin
         sample_prev6 <= prev_toggle;
         reads_seen <= (reads_seen == 2'b10) ? 2'b10 : reads_seen + 2'b01;
      end
   end

endmodule
`default_nettype wire

// file: nor_flash_host_map.vh
// Purpose: Register offsets, field positions, reset values and bus timing counts of the NOR flash host.
// Assumes: 250 MHz clock, AXI4-Lite register port with 32-bit data.
// Notes:   Times are in ns as for the flash bus; the cycle counts are derived from them.
`ifndef NOR_FLASH_HOST_MAP_VH
`define NOR_FLASH_HOST_MAP_VH

`define CLK_PERIOD_NS 4
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// Flash bus timing
// ----------------------------------------
`define T_SETUP_NS 10
`define T_READ_ACCESS_NS 90
`define T_WRITE_PULSE_NS 35
`define T_RECOVER_NS 20
`define SETUP_CYC `NS_TO_CYC(`T_SETUP_NS)
`define READ_CYC `NS_TO_CYC(`T_READ_ACCESS_NS)
`define WRITE_CYC `NS_TO_CYC(`T_WRITE_PULSE_NS)
`define RECOVER_CYC `NS_TO_CYC(`T_RECOVER_NS)

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0C
`define REG_STATUS 8'h10
`define REG_CONFIG 8'h14
`define REG_INT_STAT 8'h18
`define REG_INT_MASK 8'h1C

// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_POLL_COMPLEMENT 3'h2
`define OP_POLL_TOGGLE 3'h3
`define OP_WAIT_READY 3'h4
`define CFG_BYTE_MODE 0
`define CFG_GUARD_LOW 1
`define CFG_RESET_ASSERT 2
`define CFG_RESET 3'h0
`define INT_OP_DONE 0
`define INT_WAIT_DONE 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: nor_flash_host_tb.sv
// Purpose: Self-checking bench of the NOR flash host against the flash model.
// Assumes: 250 MHz clock; bready and rready stay high, which the bus allows.
// Notes: Each scenario task judges its own results.
`timescale 1ns/1ps
`default_nettype none
`include "nor_flash_host_map.vh"
module nor_flash_host_tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic arready, rvalid, irq, byte_addr_lsb, flash_dq_oe, chip_select_n, write_strobe_n;
   logic output_drive_n, width_select_n, flash_reset_n, edge_sector_guard_boost, ready_busy_out;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [21:0] flash_addr;
   logic [15:0] flash_dq_out, flash_dq_in, fm_dq;
   logic [22:0] last_wr;
   int error_cnt = 0, check_count = 0, cyc = 0;
   nor_flash_host u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
      .flash_addr(flash_addr), .byte_addr_lsb(byte_addr_lsb), .flash_dq_out(flash_dq_out),
      .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
      .width_select_n(width_select_n), .flash_reset_n(flash_reset_n),
      .edge_sector_guard_boost(edge_sector_guard_boost), .ready_busy_out(ready_busy_out));
   // A long busy time leaves room to suspend a running program before it ends.
   flash_model #(.BUSY(60)) u_fm (.clk(aclk), .addr(flash_addr), .lsb(byte_addr_lsb), .dq_wr(flash_dq_in),
      .cs_n(chip_select_n), .we_n(write_strobe_n), .oe_n(output_drive_n), .rst_n(flash_reset_n),
      .guard_n(edge_sector_guard_boost), .dq_rd(fm_dq), .rdy(ready_busy_out), .last_wr(last_wr));
   assign flash_dq_in = flash_dq_oe ? flash_dq_out : fm_dq;
   task automatic end_of_test;
      $display("Checks %0d, errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad, wd;
      {ad, wd} = 2'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         ad = ad | awready;
         wd = wd | wready;
         if (ad) awvalid <= 0;
         if (wd) wvalid <= 0;
      end
      do @(posedge aclk); while (!bvalid);
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      chk(n, e, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask
   task automatic op(input logic [2:0] c);
      logic [31:0] d;
      logic [1:0] r;
      axw(`REG_CTRL, {29'h0, c}, `RESP_OKAY);
      do axr(`REG_STATUS, d, r); while (d[0] !== 1'b0);
   endtask
   task automatic fw(input logic [31:0] a, input logic [31:0] d);
      axw(`REG_ADDR, a, `RESP_OKAY);
      axw(`REG_WDATA, d, `RESP_OKAY);
      op(`OP_WRITE);
   endtask
   task automatic prog(input logic [31:0] a, input logic [31:0] d, input logic [2:0] w);
      fw(a, 32'hA0);
      fw(a, d);
      axw(`REG_WDATA, d, `RESP_OKAY);
      op(w);
   endtask
   task automatic fr(input logic [31:0] a, input logic [31:0] e);
      axw(`REG_ADDR, a, `RESP_OKAY);
      op(`OP_READ);
      rchk("array", `REG_RDATA, e, `RESP_OKAY);
   endtask
   task automatic t_regs;
      chk("width pin", 32'h1, width_select_n);
      chk("guard pin", 32'h1, edge_sector_guard_boost);
      chk("reset pin", 32'h1, flash_reset_n);
      rchk("config", `REG_CONFIG, 32'h0, `RESP_OKAY);
      rchk("unmapped", 8'h20, 32'h0, `RESP_SLVERR);
      axw(`REG_STATUS, 32'h0, `RESP_SLVERR);
      axw(`REG_INT_MASK, 32'h3, `RESP_OKAY);
      rchk("mask", `REG_INT_MASK, 32'h3, `RESP_OKAY);
      axw(`REG_INT_MASK, 32'h0, `RESP_OKAY);
   endtask
   task automatic t_prog;
      prog(32'h5, 32'h1234, `OP_WAIT_READY);
      fr(32'h5, 32'h1234);
      fw(32'h5, 32'h0);
      fr(32'h5, 32'h1234);
      prog(32'h5, 32'hFFFF, `OP_WAIT_READY);
      fr(32'h5, 32'h1234);
      chk("irq masked", 32'h0, irq);
   endtask
   task automatic t_wait;
      logic [2:0] ops [3] = '{`OP_WAIT_READY, `OP_POLL_COMPLEMENT, `OP_POLL_TOGGLE};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 3; i++)
      begin
         axr(`REG_INT_STAT, d, r);
         axw(`REG_INT_MASK, i == 2 ? 32'h0 : 32'h2, `RESP_OKAY);
         prog(32'h8 + i, 32'h5A80 + i, ops[i]);
         @(posedge aclk);
         chk("ready pin", 32'h1, ready_busy_out);
         chk("irq", {31'h0, i != 2}, irq);
         rchk("int stat", `REG_INT_STAT, 32'h3, `RESP_OKAY);
         @(posedge aclk);
         chk("irq cleared", 32'h0, irq);
         fr(32'h8 + i, 32'h5A80 + i);
         rchk("status", `REG_STATUS, 32'h4, `RESP_OKAY);
      end
   endtask
   task automatic t_byte;
      axw(`REG_CONFIG, 32'h1, `RESP_OKAY);
      @(posedge aclk);
      chk("width pin", 32'h0, width_select_n);
      fw(32'hB, 32'h0);
      chk("byte address", {9'h0, 22'h5, 1'b1}, last_wr);
      axw(`REG_CONFIG, 32'h0, `RESP_OKAY);
      @(posedge aclk);
      chk("width pin", 32'h1, width_select_n);
   endtask
   task automatic t_guard;
      axw(`REG_CONFIG, 32'h2, `RESP_OKAY);
      @(posedge aclk);
      chk("guard pin", 32'h0, edge_sector_guard_boost);
      prog(32'h0, 32'h0F0F, `OP_WAIT_READY);
      fr(32'h0, 32'hFFFF);
      axw(`REG_CONFIG, 32'h0, `RESP_OKAY);
   endtask
   task automatic t_susp;
      fw(32'hC, 32'hA0);
      fw(32'hC, 32'h1111);
      fw(32'hC, 32'hB0);
      chk("ready in suspend", 32'h1, ready_busy_out);
      fr(32'h3, 32'hFFFF);
      fw(32'hC, 32'h30);
      chk("busy after resume", 32'h0, ready_busy_out);
      axw(`REG_WDATA, 32'h1111, `RESP_OKAY);
      op(`OP_POLL_COMPLEMENT);
      fr(32'hC, 32'h1111);
   endtask
   task automatic t_reset;
      fw(32'h7, 32'hA0);
      fw(32'h7, 32'h0);
      chk("busy pin", 32'h0, ready_busy_out);
      axw(`REG_CONFIG, 32'h4, `RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("reset pin", 32'h0, flash_reset_n);
      chk("ready pin", 32'h1, ready_busy_out);
      axw(`REG_CONFIG, 32'h0, `RESP_OKAY);
      fr(32'h7, 32'hFFFF);
   endtask
   initial
   begin
      aclk = 0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         error_cnt++;
         end_of_test;
      end
   end
   initial
   begin
      {awvalid, wvalid, arvalid, awaddr, araddr, wdata, aresetn} = '0;
      {bready, rready, wstrb} = 6'h3F;
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      t_regs;
      t_prog;
      t_wait;
      t_byte;
      t_guard;
      t_susp;
      t_reset;
      end_of_test;
   end
endmodule
bind nor_flash_host flash_bus_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (.aclk(aclk), .aresetn(aresetn),
   .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
   .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
   .flash_reset_n(flash_reset_n));
`default_nettype wire
